// [rtl/flow_ctrl_defines.svh]
// Constants for the program-flow, flag and index control block
`ifndef FLOW_CTRL_DEFINES_SVH
`define FLOW_CTRL_DEFINES_SVH
`define OPC_MSB           15
`define OPC_LSB           12
`define OPC_RETURN        4'h3
`define OPC_JUMP_TRUE     4'hA
`define OPC_JUMP_FALSE    4'hB
`define OPC_FLAG_WRITE    4'hC
`define OPC_INDEX_OP      4'hD
`define OPC_CALL_TRUE     4'hE
`define OPC_CALL_FALSE    4'hF
`define FLAG_SEL_MSB      11
`define FLAG_SEL_LSB      9
`define ADDR_MSB          8
`define ADDR_LSB          0
`define VALUE_BIT         0
`define IDX_SUB_MSB       11
`define IDX_SUB_LSB       9
`define IDX_SUB_LOAD      3'h0
`define IDX_SUB_ADD       3'h1
`define IDX_SUB_ACC       3'h4
`define IDX_IMM_MSB       5
`define IDX_IMM_LSB       0
`define ACC_POINT         24
`define PC_RESET          9'h000
`define INDEX_RESET       6'h00
`define FLAGS_RESET       3'h0
`define SEL_USER_A        3'h5
`define SEL_USER_B        3'h6
`define SEL_USER_C        3'h7
`define PROG_DEPTH        512
`endif

// [rtl/flow_ctrl_pkg.sv]
// Types for the program-flow, flag and index control block
package flow_ctrl_pkg;
  typedef logic [8:0]  prog_addr_type;
  typedef logic [15:0] instr_type;
  typedef logic [5:0]  index_type;
endpackage : flow_ctrl_pkg

// [rtl/program_ram.sv]
// Program memory with one write port and one read port
`timescale 1ns/1ns
`include "flow_ctrl_defines.svh"
module program_ram (
  input  wire logic                          clk,
  input  wire logic                          wr_en,
  input  wire flow_ctrl_pkg::prog_addr_type  wr_addr,
  input  wire flow_ctrl_pkg::instr_type      wr_data,
  input  wire flow_ctrl_pkg::prog_addr_type  rd_addr,
  output      flow_ctrl_pkg::instr_type      rd_data
);
  flow_ctrl_pkg::instr_type mem [0:`PROG_DEPTH-1];

  // Combinational read so the fetched word matches the current counter
  assign rd_data = mem[rd_addr];

  // Loader write port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule : program_ram

// [rtl/flow_control.sv]
// Program-flow, flag and index control of the voice signal processor decoder
// Function
// - nibble 1010 jumps when selected flag set
// - nibble 1011 jumps when selected flag clear
// - nibble 1110 calls when selected flag set
// - nibble 1111 calls when selected flag clear
// - return stack holds one entry, no nesting
// - nibble 0011 returns from stack entry
// - nibble 1100 writes bit 0 to user flag
// - flag writes never change system flags
// - nibble 1101 loads, adds or copies index
// - index additions wrap modulo 64
// - accumulator copy takes six integer bits
// - program memory of 512 instructions
// - execution starts at address 0
// - loader commands fill program RAM
// - equality flags update from arithmetic results
`timescale 1ns/1ns
`include "flow_ctrl_defines.svh"
module flow_control (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          run,
  input  wire logic                          load_valid,
  input  wire flow_ctrl_pkg::prog_addr_type  load_addr,
  input  wire flow_ctrl_pkg::instr_type      load_data,
  input  wire logic                          arith_valid,
  input  wire logic                          arith_zero,
  input  wire logic                          arith_negative,
  input  wire logic [2:0]                    hw_flags,
  input  wire logic [31:0]                   accumulator,
  output      flow_ctrl_pkg::prog_addr_type  pc,
  output      flow_ctrl_pkg::instr_type      instr,
  output      flow_ctrl_pkg::index_type      index_reg,
  output      logic [2:0]                    user_flags,
  output      logic                          equality_flag_low,
  output      logic                          equality_flag_high,
  output      flow_ctrl_pkg::prog_addr_type  return_entry
);
  // ************************************************************
  // Program memory
  // ************************************************************
  flow_ctrl_pkg::instr_type fetched;

  // Loader writes and execution fetch share the array
  program_ram u_ram (
    .clk     (clk),
    .wr_en   (load_valid),
    .wr_addr (load_addr),
    .wr_data (load_data),
    .rd_addr (pc),
    .rd_data (fetched)
  );

  assign instr = fetched;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  logic [3:0] opcode;
  logic [2:0] sel;
  assign opcode = fetched[`OPC_MSB:`OPC_LSB];
  assign sel    = fetched[`FLAG_SEL_MSB:`FLAG_SEL_LSB];

  // Selected flag: 0..1 equality, 2..4 hardware system, 5..7 user
  function automatic logic pick_flag(input logic [2:0] s, input logic e0, input logic e1,
                                     input logic [2:0] hw, input logic [2:0] usr);
    logic r;
    r = 1'b0;
    unique case (s)
      3'h0: r = e0;
      3'h1: r = e1;
      3'h2: r = hw[0];
      3'h3: r = hw[1];
      3'h4: r = hw[2];
      3'h5: r = usr[0];
      3'h6: r = usr[1];
      3'h7: r = usr[2];
    endcase
    return r;
  endfunction : pick_flag

  logic flag_now;
  assign flag_now = pick_flag(sel, equality_flag_low, equality_flag_high, hw_flags, user_flags);

  // ************************************************************
  // Next-state computation
  // ************************************************************
  flow_ctrl_pkg::prog_addr_type next_pc;
  flow_ctrl_pkg::prog_addr_type next_return_entry;
  flow_ctrl_pkg::prog_addr_type pc_plus;
  flow_ctrl_pkg::prog_addr_type target;
  flow_ctrl_pkg::index_type     next_index_reg;
  logic [2:0]                   next_user_flags;
  logic                         next_eq_low;
  logic                         next_eq_high;

  assign pc_plus = flow_ctrl_pkg::prog_addr_type'(pc + 9'h001);
  assign target  = fetched[`ADDR_MSB:`ADDR_LSB];

  // Decodes one instruction per cycle while running
  always_comb begin
    next_pc           = pc;
    next_return_entry = return_entry;
    next_index_reg    = index_reg;
    next_user_flags   = user_flags;
    next_eq_low       = equality_flag_low;
    next_eq_high      = equality_flag_high;
    if (run) begin
      next_pc = pc_plus;
      unique case (opcode)
        `OPC_JUMP_TRUE: begin
          if (flag_now) next_pc = target;
        end
        `OPC_JUMP_FALSE: begin
          if (!flag_now) next_pc = target;
        end
        `OPC_CALL_TRUE: begin
          if (flag_now) begin
            next_return_entry = pc_plus;
            next_pc           = target;
          end
        end
        `OPC_CALL_FALSE: begin
          if (!flag_now) begin
            next_return_entry = pc_plus;
            next_pc           = target;
          end
        end
        `OPC_RETURN: begin
          next_pc = return_entry;
        end
        `OPC_FLAG_WRITE: begin
          // Only user selectors write; system selectors are left alone
          if (sel == `SEL_USER_A) next_user_flags[0] = fetched[`VALUE_BIT];
          if (sel == `SEL_USER_B) next_user_flags[1] = fetched[`VALUE_BIT];
          if (sel == `SEL_USER_C) next_user_flags[2] = fetched[`VALUE_BIT];
        end
        `OPC_INDEX_OP: begin
          unique case (fetched[`IDX_SUB_MSB:`IDX_SUB_LSB])
            `IDX_SUB_LOAD: next_index_reg = fetched[`IDX_IMM_MSB:`IDX_IMM_LSB];
            `IDX_SUB_ADD:  next_index_reg = flow_ctrl_pkg::index_type'(
                             index_reg + fetched[`IDX_IMM_MSB:`IDX_IMM_LSB]);
            `IDX_SUB_ACC:  next_index_reg =
                             accumulator[`ACC_POINT+5:`ACC_POINT];
            default:       next_index_reg = index_reg; // Undefined sub-codes do nothing
          endcase
        end
        default: next_pc = pc_plus;
      endcase
    end
    // Arithmetic results from the datapath refresh the equality flags
    if (arith_valid) begin
      next_eq_low  = arith_zero;
      next_eq_high = arith_negative;
    end
  end

  // ************************************************************
  // State registers
  // ************************************************************
  // Registers only; reset starts execution at address 0
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc                 <= `PC_RESET;
      return_entry       <= `PC_RESET;
      index_reg          <= `INDEX_RESET;
      user_flags         <= `FLAGS_RESET;
      equality_flag_low  <= 1'h0;
      equality_flag_high <= 1'h0;
    end else begin
      pc                 <= next_pc;
      return_entry       <= next_return_entry;
      index_reg          <= next_index_reg;
      user_flags         <= next_user_flags;
      equality_flag_low  <= next_eq_low;
      equality_flag_high <= next_eq_high;
    end
  end
endmodule : flow_control

// [verification/host_loader.sv]
// Host model that writes program words
`timescale 1ns/1ns
module host_loader (
  input  logic        clk,
  input  logic        put,
  input  logic [24:0] cmd,
  output logic        load_valid,
  output logic [8:0]  load_addr,
  output logic [15:0] load_data
);
  // One word per clock, idle bus inverted
  always_ff @(posedge clk) begin
    load_valid <= put;
    {load_addr, load_data} <= put ? cmd : ~{load_addr, load_data};
  end
endmodule : host_loader

// [verification/flow_control_properties.sv]
// Port assertions of the flow control block
`timescale 1ns/1ns
module flow_control_properties (
  input logic        clk,
  input logic        rst_n,
  input logic        run,
  input logic [15:0] instr,
  input logic [8:0]  pc,
  input logic [8:0]  return_entry,
  input logic [5:0]  index_reg,
  input logic [2:0]  user_flags,
  input logic [2:0]  hw_flags,
  input logic        equality_flag_low,
  input logic        equality_flag_high,
  input logic        arith_valid,
  input logic        arith_zero,
  input logic        arith_negative,
  input logic [31:0] accumulator
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Selected flag, executed opcode, condition met
  wire [7:0] fv = {user_flags, hw_flags, equality_flag_high, equality_flag_low};
  wire [3:0] op = run ? instr[15:12] : 4'h0;
  wire       hit = fv[instr[11:9]] != op[0];
  sequence s_call;
    op[3:1] == 3'h7 && hit;
  endsequence
  AST_JUMP: assert property (op[3:1] == 3'h5 |=> pc ==
    ($past(hit) ? $past(instr[8:0]) : $past(pc) + 9'h001)) else $error("jump");
  AST_CALL: assert property (s_call |=> pc == $past(instr[8:0]) &&
    return_entry == $past(pc) + 9'h001) else $error("call");
  AST_RET: assert property (op == 4'h3 |=> pc == $past(return_entry)) else $error("ret");
  AST_FLAG: assert property (op == 4'hC && instr[11] && instr[10:9] != 2'h0 |=>
    user_flags[$past(instr[10:9]) - 2'h1] == $past(instr[0])) else $error("flag");
  AST_SYSFLAG: assert property (op == 4'hC && instr[11:9] < 3'h5 |=>
    $stable(user_flags)) else $error("sysflag");
  AST_IDX_ADD: assert property (op == 4'hD && instr[11:9] == 3'h1 |=>
    index_reg == $past(index_reg) + $past(instr[5:0])) else $error("idx add");
  AST_IDX_LOAD: assert property (op == 4'hD && instr[11:9] == 3'h0 |=>
    index_reg == $past(instr[5:0])) else $error("idx load");
  AST_IDX_ACC: assert property (op == 4'hD && instr[11:9] == 3'h4 |=>
    index_reg == $past(accumulator[29:24])) else $error("idx acc");
  AST_EQ: assert property (arith_valid |=> equality_flag_low == $past(arith_zero) &&
    equality_flag_high == $past(arith_negative)) else $error("eq");
endmodule : flow_control_properties
bind flow_control flow_control_properties chk (.*);

// [verification/flow_control_tb.sv]
// Self-checking bench of the flow control block
`timescale 1ns/1ns
module flow_control_tb;
  logic clk = 1'h0, rst_n = 1'h0, run = 1'h0, put = 1'h0, load_valid;
  logic arith_valid = 1'h0, arith_zero = 1'h0, arith_negative = 1'h0;
  logic equality_flag_low, equality_flag_high;
  logic [2:0] hw_flags = 3'h2, user_flags;
  logic [31:0] accumulator = 32'h6A000000;
  logic [24:0] cmd = 25'h0;
  logic [8:0] load_addr, pc, return_entry;
  logic [15:0] load_data, instr;
  logic [5:0] index_reg;
  int n_fail = 0, compares = 0;
  logic [24:0] prog [12] = '{25'h000CA01, 25'h001C201, 25'h002AA05, 25'h005BA07,
    25'h006EC0A, 25'h007FC0A, 25'h00AD001, 25'h00BD23F, 25'h00CD800, 25'h00D3000,
    25'h008E7FF, 25'h1FF3FFF};
  logic [8:0] trace [12] = '{9'h001, 9'h002, 9'h005, 9'h006, 9'h007, 9'h00A, 9'h00B,
    9'h00C, 9'h00D, 9'h008, 9'h1FF, 9'h009};
  always #25 clk = ~clk;
  host_loader HOST (.*);
  flow_control DUT (.*);
  // Compare and count
  task automatic chk(input logic [15:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  // Load while halted, then run calls, jumps and index ops
  task automatic t_prog();
    foreach (prog[i]) begin
      cmd = prog[i];
      put = 1'h1;
      step();
    end
    put = 1'h0;
    step();
    run = 1'h1;
    foreach (trace[i]) begin
      step();
      chk(pc, trace[i], "pc");
    end
    run = 1'h0;
    chk(index_reg, 6'h2A, "idx");
    chk({user_flags, equality_flag_high}, 4'h2, "flags");
    chk(return_entry, 9'h009, "stack");
    $display("program test done");
  endtask : t_prog
  // Results update equality flags while halted
  task automatic t_arith();
    {arith_valid, arith_zero, arith_negative} = 3'h6;
    step();
    chk({equality_flag_low, equality_flag_high}, 2'h2, "eq");
    {arith_valid, arith_zero, arith_negative} = 3'h5;
    step();
    arith_valid = 1'h0;
    chk({equality_flag_low, equality_flag_high}, 2'h1, "eq");
    $display("arith test done");
  endtask : t_arith
  // Reset while halted, then restart from address zero
  task automatic t_reset();
    rst_n = 1'h0;
    step();
    rst_n = 1'h1;
    chk({pc, index_reg}, 15'h0, "pc idx");
    chk({return_entry, user_flags}, 12'h0, "stack");
    chk(instr, 16'hCA01, "instr");
    run = 1'h1;
    step();
    run = 1'h0;
    chk(pc, 9'h001, "pc");
    $display("reset test done");
  endtask : t_reset
  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) step();
    rst_n = 1'h1;
    t_prog();
    t_arith();
    t_reset();
    complete_run();
  end
endmodule : flow_control_tb
